// ===== src/ccp_pkg.sv
package ccp_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_VAL_LOW = 4'h4;
  localparam logic [3:0] OFS_VAL_HIGH = 4'h8;
  localparam logic [3:0] OFS_FLAGS = 4'hc;
  // Control register fields
  localparam int MODE_LSB = 0;
  localparam int DUTY_LSB = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h3f;
  // Flag register fields
  localparam int FLAG_EVENT_BIT = 0;
  localparam int FLAG_ENABLE_BIT = 1;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // Prescaler thresholds, as counts minus one
  localparam logic [3:0] PRESC_FOUR = 4'h3;
  localparam logic [3:0] PRESC_SIXTEEN = 4'hf;
  // Mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
  typedef enum logic [1:0] {
    KIND_OFF,
    KIND_CAPTURE,
    KIND_COMPARE,
    KIND_PWM
  } unit_kind_t;
endpackage : ccp_pkg

// ===== src/ccp_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_edge_detect (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pinLevel,
  output logic riseSeen,
  output logic fallSeen
);
  logic sync1_ff, sync2_ff, last_ff;
  logic nxt_sync1, nxt_sync2, nxt_last;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser, then one stage for edge history
  always_comb begin
    nxt_sync1 = pinLevel;
    nxt_sync2 = sync1_ff;
    nxt_last = sync2_ff;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      last_ff <= nxt_last;
    end
  end

  // Only the second stage and history feed the edge terms
  assign riseSeen = sync2_ff & ~last_ff;
  assign fallSeen = ~sync2_ff & last_ff;
endmodule : ccp_edge_detect
`default_nettype wire

// ===== src/ccp_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_prescaler (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clearCount,
  input wire logic edgeIn,
  input wire logic [3:0] limit,
  output logic eventOut
);
  import ccp_pkg::*;
  logic [3:0] count_ff;
  logic [3:0] nxt_count;

  ////////////////////////////////////////////////////////////////////////
  // Edge counter; a changed limit keeps the count
  always_comb begin
    nxt_count = count_ff;
    eventOut = 1'b0;
    if (clearCount) begin
      nxt_count = 4'h0;
    end else if (edgeIn) begin
      if (count_ff >= limit) begin
        nxt_count = 4'h0;
        eventOut = 1'b1;
      end else begin
        nxt_count = count_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_ff <= 4'h0;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule : ccp_prescaler
`default_nettype wire

// ===== src/ccp_capture_compare_unit.sv
// Summary of operation
// - Mode zero switches unit off, resets state.
// - Codes 4-7 capture fall, rise, 4th, 16th.
// - Match in 8/9 drives output high/low, flags.
// - Mode 10 match only sets the flag.
// - Mode 11 flags, resets timer, starts conversion.
// - 110x PWM high, 111x PWM low polarity.
// - Capture copies full timer into value pair.
// - Capture sets flag; only software clears it.
// - New capture overwrites stored value silently.
// - Port latch edges count when pin outputs.
// - Prescaler cleared when off, non-capture, reset.
// - Prescale change keeps count, may capture falsely.
// - Capture mode change may set flag falsely.
// - Compare value pair against timer every cycle.
// - Bits 5-4 hold duty low bits, unused here.
// - Bits 7-6 read as zero.
// - Special event same cycle; timer resets next edge.
// - Zero control forces compare latch low.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ccp_capture_compare_unit (
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  // Pin and timer side
  input wire logic unitPinIn,
  input wire logic pinDirectionBit,
  input wire logic portLatchLevel,
  input wire logic [15:0] timerOneCount,
  input wire logic timerOneTick,
  input wire logic converterEnabled,
  output logic compareOut,
  output logic compareOutActive,
  output logic specialEvent,
  output logic timerOneReset,
  output logic conversionStart,
  output logic unitEventFlag,
  output logic unitEventEnable,
  output logic [1:0] dutyLowBits,
  output logic pwmActiveLow
);
  import ccp_pkg::*;

  logic [5:0] control_ff, nxt_control;
  logic [15:0] value_ff, nxt_value;
  logic flag_ff, nxt_flag;
  logic enable_ff, nxt_enable;
  logic cmpOut_ff, nxt_cmpOut;
  logic resetPend_ff, nxt_resetPend;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err;
  logic [3:0] unitModeSelect;
  unit_kind_t kind;
  logic riseSeen, fallSeen, chosenEdge, captureEvent;
  logic clearPresc, match, matchPulse, lastMatch_ff, nxt_lastMatch;
  logic [3:0] prescLimit;
  logic access, wrCtl, wrLow, wrHigh, wrFlags;

  assign unitModeSelect = control_ff[MODE_LSB +: 4];
  assign dutyLowBits = control_ff[DUTY_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb begin
    unique case (unitModeSelect[3:2])
      2'b00: kind = KIND_OFF;
      2'b01: kind = KIND_CAPTURE;
      2'b10: kind = KIND_COMPARE;
      2'b11: kind = KIND_PWM;
    endcase
  end
  assign pwmActiveLow = (kind == KIND_PWM) & unitModeSelect[1];

  ////////////////////////////////////////////////////////////////////////
  // Capture edge source: pin when input, port latch when output
  ccp_edge_detect u_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinLevel(pinDirectionBit ? unitPinIn : portLatchLevel),
    .riseSeen(riseSeen),
    .fallSeen(fallSeen)
  );

  // Edge choice and prescale limit per capture code
  always_comb begin
    chosenEdge = riseSeen;
    prescLimit = 4'h0;
    unique case (unitModeSelect)
      MODE_CAP_FALL: chosenEdge = fallSeen;
      MODE_CAP_RISE4: prescLimit = PRESC_FOUR;
      MODE_CAP_RISE16: prescLimit = PRESC_SIXTEEN;
      default: prescLimit = 4'h0;
    endcase
  end
  assign clearPresc = (kind != KIND_CAPTURE);

  ccp_prescaler u_presc (
    .mclk(mclk),
    .rst_n(rst_n),
    .clearCount(clearPresc),
    .edgeIn(chosenEdge & (kind == KIND_CAPTURE)),
    .limit(prescLimit),
    .eventOut(captureEvent)
  );

  ////////////////////////////////////////////////////////////////////////
  // Compare, evaluated every cycle; one pulse per match onset
  assign match = (kind == KIND_COMPARE) && (value_ff == timerOneCount);
  assign matchPulse = match & ~lastMatch_ff;
  assign specialEvent = matchPulse && (unitModeSelect == MODE_CMP_SPECIAL);
  assign conversionStart = specialEvent & converterEnabled;
  // Reset waits for timer tick; lost if match goes away first
  assign timerOneReset = resetPend_ff & timerOneTick & match;
  assign compareOut = cmpOut_ff;
  assign compareOutActive = (unitModeSelect == MODE_CMP_SET) ||
                            (unitModeSelect == MODE_CMP_CLR);
  assign unitEventFlag = flag_ff;
  assign unitEventEnable = enable_ff;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; every access answers one cycle later
  assign access = (avs_read | avs_write) & ~ack_ff;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wrCtl = access & avs_write && avs_address == OFS_CONTROL;
  assign wrLow = access & avs_write && avs_address == OFS_VAL_LOW;
  assign wrHigh = access & avs_write && avs_address == OFS_VAL_HIGH;
  assign wrFlags = access & avs_write && avs_address == OFS_FLAGS;
  assign avs_readdata = rdata_ff;
  assign avs_response_err = err_ff;

  ////////////////////////////////////////////////////////////////////////
  // Next state for registers, flags and the output latch
  always_comb begin
    nxt_control = control_ff;
    nxt_value = value_ff;
    nxt_flag = flag_ff;
    nxt_enable = enable_ff;
    nxt_cmpOut = cmpOut_ff;
    nxt_resetPend = resetPend_ff;
    nxt_lastMatch = match;
    nxt_ack = access;
    nxt_rdata = 32'h0000_0000;
    nxt_err = access && (avs_address != OFS_CONTROL) &&
              (avs_address != OFS_VAL_LOW) && (avs_address != OFS_VAL_HIGH) &&
              (avs_address != OFS_FLAGS);
    // Software writes, byte 0 lane only holds these registers
    if (wrCtl && avs_byteenable[0]) begin
      nxt_control = avs_writedata[5:0] & CONTROL_WMASK[5:0];
    end
    if (wrLow) begin
      if (avs_byteenable[0]) nxt_value[7:0] = avs_writedata[7:0];
    end
    if (wrHigh) begin
      if (avs_byteenable[0]) nxt_value[15:8] = avs_writedata[7:0];
    end
    if (wrFlags && avs_byteenable[0]) begin
      nxt_flag = avs_writedata[FLAG_EVENT_BIT];
      nxt_enable = avs_writedata[FLAG_ENABLE_BIT];
    end
    // Capture overwrites any unread value
    if (captureEvent) begin
      nxt_value = timerOneCount;
    end
    // Match actions per compare code
    nxt_resetPend = resetPend_ff & match & ~timerOneTick;
    if (matchPulse) begin
      unique case (unitModeSelect)
        MODE_CMP_SET: nxt_cmpOut = 1'b1;
        MODE_CMP_CLR: nxt_cmpOut = 1'b0;
        MODE_CMP_SPECIAL: nxt_resetPend = 1'b1;
        default: nxt_cmpOut = cmpOut_ff;
      endcase
    end
    // Hardware set beats a simultaneous software clear
    if (captureEvent || matchPulse) begin
      nxt_flag = 1'b1;
    end
    // Off or reserved code: drop unit state
    if (kind == KIND_OFF) begin
      nxt_cmpOut = 1'b0;
      nxt_resetPend = 1'b0;
    end
    if (wrCtl && avs_byteenable[0] && avs_writedata[3:0] == MODE_OFF) begin
      nxt_cmpOut = 1'b0;
      nxt_resetPend = 1'b0;
    end
    // Read data, upper bits zero
    if (access && avs_read) begin
      unique case (avs_address)
        OFS_CONTROL: nxt_rdata = {26'h0, control_ff};
        OFS_VAL_LOW: nxt_rdata = {24'h0, value_ff[7:0]};
        OFS_VAL_HIGH: nxt_rdata = {24'h0, value_ff[15:8]};
        OFS_FLAGS: nxt_rdata = {30'h0, enable_ff, flag_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control_ff <= CONTROL_RESET[5:0];
      value_ff <= VALUE_RESET;
      flag_ff <= 1'b0;
      enable_ff <= 1'b0;
      cmpOut_ff <= 1'b0;
      resetPend_ff <= 1'b0;
      lastMatch_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      control_ff <= nxt_control;
      value_ff <= nxt_value;
      flag_ff <= nxt_flag;
      enable_ff <= nxt_enable;
      cmpOut_ff <= nxt_cmpOut;
      resetPend_ff <= nxt_resetPend;
      lastMatch_ff <= nxt_lastMatch;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end
endmodule : ccp_capture_compare_unit
`default_nettype wire

// ===== testbench/ccp_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_checker
  import ccp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic compareOut,
  input wire logic compareOutActive,
  input wire logic specialEvent,
  input wire logic conversionStart,
  input wire logic converterEnabled,
  input wire logic unitEventFlag,
  input wire logic [1:0] dutyLowBits,
  input wire logic pwmActiveLow
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Request onset and an accepted control write
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_ctl;
    avs_write && !avs_waitrequest && avs_address == OFS_CONTROL
      && avs_byteenable[0];
  endsequence
  a_wait_one:
    assert property (s_req |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer late");
  a_duty_copy:
    assert property (s_ctl |=> dutyLowBits == $past(avs_writedata[5:4]))
    else $error("duty bits wrong");
  a_pwm_pol:
    assert property (s_ctl |=>
      pwmActiveLow == ($past(avs_writedata[3:1]) == 3'b111))
    else $error("polarity wrong");
  a_cmp_active:
    assert property (s_ctl |=>
      compareOutActive == ($past(avs_writedata[3:1]) == 3'b100))
    else $error("pin drive wrong");
  a_zero_low:
    assert property (s_ctl ##0 avs_writedata[5:0] == 6'h00 |=> !compareOut)
    else $error("latch not low");
  a_conv_gate:
    assert property (conversionStart == (specialEvent && converterEnabled))
    else $error("conversion gate");
  a_event_pulse:
    assert property (specialEvent |=> !specialEvent)
    else $error("event too long");
  a_flag_keep:
    assert property ($fell(unitEventFlag) |-> $past(avs_write
      && avs_waitrequest && avs_address == OFS_FLAGS))
    else $error("flag cleared by hardware");
endmodule : ccp_checker
`default_nettype wire
bind ccp_capture_compare_unit ccp_checker u_chk (.*);

// ===== testbench/ccp_far_side.sv
`timescale 1ns/1ns
`default_nettype none
module ccp_far_side (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic pinCmd,
  input wire logic dirBit,
  input wire logic latch,
  input wire logic timerOneReset,
  output logic [15:0] timerOneCount,
  output logic timerOneTick,
  output logic unitPinIn
);
  logic phase_ff;
  logic [15:0] cnt_ff;
  // Synchronous timer, ticks every other cycle so a match lasts two
  assign timerOneTick = phase_ff && run;
  assign timerOneCount = cnt_ff;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end else begin
      phase_ff <= !phase_ff;
      if (timerOneTick && timerOneReset) begin
        cnt_ff <= 16'h0000;
      end else if (timerOneTick) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
  // Input pin follows the far driver, an output pin the port latch
  assign unitPinIn = dirBit ? pinCmd : latch;
endmodule : ccp_far_side
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ccp_pkg::*;
  logic mclk, rst_n, avs_read, avs_write, run, pinCmd, dirBit, latch, convEn;
  logic avs_waitrequest, avs_response_err, unitPinIn, tick, tmrRst, cmpOut;
  logic flag;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rnd;
  logic [15:0] tmr, val;
  logic [32:0] notes[$];
  int err_total, checked, i, k, n;
  ccp_capture_compare_unit u_dut (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .unitPinIn(unitPinIn),
    .pinDirectionBit(dirBit), .portLatchLevel(latch), .timerOneCount(tmr),
    .timerOneTick(tick), .converterEnabled(convEn), .compareOut(cmpOut),
    .compareOutActive(), .specialEvent(), .timerOneReset(tmrRst),
    .conversionStart(), .unitEventFlag(flag), .unitEventEnable(),
    .dutyLowBits(), .pwmActiveLow());
  ccp_far_side u_far (.mclk(mclk), .rst_n(rst_n), .run(run), .pinCmd(pinCmd),
    .dirBit(dirBit), .latch(latch), .timerOneReset(tmrRst),
    .timerOneCount(tmr), .timerOneTick(tick), .unitPinIn(unitPinIn));
  ////////////////////////////////////////
  // Clock, 8 ns period
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do @(posedge mclk); while (avs_waitrequest);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task rd(input logic [3:0] a, input logic [32:0] e);
    notes.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd
  // Full pulses on whichever source the direction bit selects
  task pulses(input int cnt);
    repeat (2 * cnt) begin
      @(posedge mclk);
      if (dirBit) pinCmd <= !pinCmd;
      else latch <= !latch;
      repeat (7) @(posedge mclk);
    end
  endtask : pulses
  task conclude();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // Read answers are matched to the oldest note
  always @(posedge mclk) begin
    if (avs_read && !avs_waitrequest)
      chk("read", {avs_response_err, avs_readdata}, notes.pop_front());
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    conclude();
  end
  // Main sequence: registers, capture modes, compare modes
  initial begin
    {rst_n, avs_read, avs_write, run, pinCmd, dirBit, latch, convEn} = '0;
    {avs_address, avs_writedata} = '0;
    rnd = 32'h0000_0014;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_CONTROL, {25'h0, CONTROL_RESET});
    rd(OFS_FLAGS, 33'h0);
    rd(4'h2, 33'h1_0000_0000);
    bus(1'b1, OFS_FLAGS, 8'h02);
    rd(OFS_FLAGS, 33'h0_0000_0002);
    bus(1'b1, OFS_CONTROL, 8'hff);
    rd(OFS_CONTROL, {25'h0, CONTROL_WMASK});
    bus(1'b1, OFS_CONTROL, 8'h03);
    pulses(1);
    chk("reserved", flag, 1'b0);
    for (k = 4; k < 8; k++) begin
      rnd = xs(rnd);
      dirBit <= rnd[0];
      convEn <= rnd[1];
      bus(1'b1, OFS_CONTROL, 8'h00);
      bus(1'b1, OFS_CONTROL, 8'(k));
      bus(1'b1, OFS_FLAGS, 8'h00);
      run <= 1'b1;
      repeat (rnd[6:2] + 3) @(posedge mclk);
      run <= 1'b0;
      n = (k == 7) ? 16 : (k == 6) ? 4 : 1;
      pulses(n - 1);
      chk("early", flag, 1'b0);
      pulses(1);
      chk("capflag", flag, 1'b1);
      // Second capture before any read must replace the value
      run <= 1'b1;
      repeat (5) @(posedge mclk);
      run <= 1'b0;
      pulses(n);
      rd(OFS_VAL_LOW, {25'h0, tmr[7:0]});
      rd(OFS_VAL_HIGH, {25'h0, tmr[15:8]});
    end
    run <= 1'b1;
    for (i = 0; i < 5; i++) begin
      k = (i == 4) ? 8 : 8 + i;
      val = tmr + 16'h0040;
      bus(1'b1, OFS_VAL_LOW, val[7:0]);
      bus(1'b1, OFS_VAL_HIGH, val[15:8]);
      bus(1'b1, OFS_FLAGS, 8'h00);
      bus(1'b1, OFS_CONTROL, 8'(k));
      for (n = 0; n < 400 && flag !== 1'b1; n++) @(posedge mclk);
      repeat (2) @(posedge mclk);
      chk("cmpflag", flag, 1'b1);
      chk("pin", cmpOut, k == 8);
      if (k == 11) chk("treset", tmr < val, 1'b1);
    end
    bus(1'b1, OFS_CONTROL, 8'h00);
    @(posedge mclk);
    chk("cleared", cmpOut, 1'b0);
    conclude();
  end
endmodule : tb
`default_nettype wire
